// *** dpsl_params.svh ***
// Constants for the debug port security lock.
`ifndef DPSL_PARAMS_SVH
`define DPSL_PARAMS_SVH
`define DPSL_KEY_WIDTH 32
// Lock key pattern; the value is arbitrary.
`define DPSL_KEY_PATTERN 32'h5A3C0F96
`define DPSL_VOTE_MIN 28
`define DPSL_LATCH_RST 32'h00000000
`define DPSL_PROT_WIDTH 2
`define DPSL_PROT_NONE 2'h0
`define DPSL_JTAG_PINS 4
`define DPSL_SWD_PINS 2
`define DPSL_PTRACE_PINS 5
`define DPSL_STRACE_PINS 1
`define DPSL_BLK_COUNT 16
`endif

// *** dpsl_pkg.sv ***
// Types for the debug port security lock.
package dpsl_pkg;
    typedef enum logic [1:0] {
        DPSL_DBG_NONE,
        DPSL_DBG_JTAG,
        DPSL_DBG_SWD
    } dpsl_dbg_t;
    typedef enum logic [1:0] {
        DPSL_TRC_NONE,
        DPSL_TRC_SERIAL,
        DPSL_TRC_PARALLEL
    } dpsl_trc_t;
    typedef enum logic [1:0] {
        DPSL_OP_ERASE,
        DPSL_OP_PROGRAM,
        DPSL_OP_VERIFY
    } dpsl_op_t;
endpackage : dpsl_pkg

// *** dpsl_vote_if.sv ***
// Carrier between the lock top and its latch store.
`timescale 1ns/1ps
interface dpsl_vote_if;
    logic [31:0] latch_q;
    logic wr_en;
    logic [31:0] wr_data;
    logic vote_ok;
    modport store (input wr_en, input wr_data, output latch_q, output vote_ok);
    modport ctrl (output wr_en, output wr_data, input latch_q, input vote_ok);
endinterface : dpsl_vote_if

// *** dpsl_latch_store.sv ***
// Rewritable latch store with registered super-majority vote.
`timescale 1ns/1ps
`include "dpsl_params.svh"
module dpsl_latch_store (
    input wire logic ref_clk, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    dpsl_vote_if.store vif // Latch write and vote port.
);
    localparam logic [31:0] KEY_PAT = `DPSL_KEY_PATTERN;
    // Power-up contents stand for an erased latch; real cells come up random.
    logic [31:0] cells_r = `DPSL_LATCH_RST;
    logic [31:0] cells_nxt;
    logic vote_r;
    logic vote_nxt;
    logic [5:0] agree;

    // Counts key bits that agree; few bit failures must not drop the lock.
    always_comb begin
        agree = 6'h00;
        for (int i = 0; i < `DPSL_KEY_WIDTH; i++) begin
            agree = agree + {5'h00, (cells_r[i] == KEY_PAT[i])};
        end
        cells_nxt = vif.wr_en ? vif.wr_data : cells_r;
        vote_nxt = (agree >= 6'(`DPSL_VOTE_MIN));
    end

    // Cells take no reset: the stored key must outlive the reset that arms the lock.
    always_ff @(posedge ref_clk) begin
        cells_r <= cells_nxt;
    end

    // Vote register; cleared by reset so no stale vote is captured.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vote_r <= 1'b0;
        end else begin
            vote_r <= vote_nxt;
        end
    end

    assign vif.latch_q = cells_r;
    assign vif.vote_ok = vote_r;
endmodule : dpsl_latch_store

// *** dpsl_lock.sv ***
// Debug port security lock top.
// Contract
// - Lock when 28 of 32 bits match.
// - Locked: all debug and test ports off.
// - Locked: latch erase or write blocked.
// - Lock sampled only at reset release.
// - Key write only without flash protection.
// - Access stays until next reset.
// - Latch readable through serial wire debug.
// - Protection raises freely, clears on erase when unlocked.
// - Block ops obey block security setting.
// - Trace pairs obey shared pin limits.
// - Parallel trace five pins, serial one.
// - All disabled claims no pins.
// - Debug starts disabled, firmware enables.
`timescale 1ns/1ps
`include "dpsl_params.svh"
module dpsl_lock (
    input wire logic ref_clk, // System clock, 25 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic key_wr, // Pulse: write key into latch.
    input wire logic [31:0] key_data, // Key value to write.
    input wire logic swd_rd, // Pulse: serial debug reads latch.
    input wire logic fw_dbg_wr, // Pulse: firmware writes debug setup.
    input wire dpsl_pkg::dpsl_dbg_t fw_dbg, // Requested debug port.
    input wire dpsl_pkg::dpsl_trc_t fw_trc, // Requested trace port.
    input wire logic prot_wr, // Pulse: raise protection level.
    input wire logic [1:0] prot_data, // New protection level.
    input wire logic full_erase, // Pulse: whole device erase.
    input wire logic blk_req, // Pulse: flash block operation.
    input wire dpsl_pkg::dpsl_op_t blk_op, // Block operation kind.
    input wire logic [3:0] blk_idx, // Block index.
    input wire logic [15:0] blk_secure, // Per-block security, 1 forbids ops.
    output logic locked, // Lock captured at reset.
    output logic [31:0] swd_rdata, // Latch contents for serial debug.
    output logic jtag_en, // JTAG port enabled.
    output logic swd_en, // Serial wire debug enabled.
    output logic strace_en, // Serial trace pin enabled.
    output logic ptrace_en, // Parallel trace port enabled.
    output logic [3:0] pins_used, // Pins claimed by debug and trace.
    output logic [1:0] prot_level, // Flash protection level.
    output logic blk_grant, // Block operation allowed.
    output logic key_refused // Key write refused.
);
    import dpsl_pkg::*;
    dpsl_vote_if vif ();
    dpsl_latch_store u_store (.ref_clk(ref_clk), .rstn(rstn), .vif(vif));

    typedef enum logic [1:0] {DPSL_ST_BOOT, DPSL_ST_VOTE, DPSL_ST_RUN} dpsl_state_t;
    dpsl_state_t st_r, st_nxt;
    logic locked_r, locked_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic jt_r, jt_nxt, sw_r, sw_nxt, st_en_r, st_en_nxt, pt_r, pt_nxt;
    logic [3:0] pins_r, pins_nxt;
    logic [1:0] prot_r, prot_nxt;
    logic grant_r, grant_nxt, ref_r, ref_nxt;

    // Pin count for a port pairing.
    function automatic logic [3:0] dpsl_pins(input logic j, input logic s,
                                             input logic t, input logic p);
        dpsl_pins = (j ? 4'(`DPSL_JTAG_PINS) : 4'h0) + (s ? 4'(`DPSL_SWD_PINS) : 4'h0)
                  + (t ? 4'(`DPSL_STRACE_PINS) : 4'h0)
                  + (p ? 4'(`DPSL_PTRACE_PINS) : 4'h0);
    endfunction : dpsl_pins

    // Key write gate; the lock blocks writes only once captured, not during reset or before the capture.
    always_comb begin
        vif.wr_en = key_wr && !locked_r && (prot_r == `DPSL_PROT_NONE);
        vif.wr_data = key_data;
    end

    // Capture the vote once after reset; a later key write leaves access open.
    // The vote register settles on the first edge after release, so the
    // capture waits one more edge and never sees the cleared reset value.
    always_comb begin
        st_nxt = st_r;
        locked_nxt = locked_r;
        unique case (st_r)
            DPSL_ST_BOOT: begin
                st_nxt = DPSL_ST_VOTE;
            end
            DPSL_ST_VOTE: begin
                locked_nxt = vif.vote_ok;
                st_nxt = DPSL_ST_RUN;
            end
            DPSL_ST_RUN: begin
                st_nxt = DPSL_ST_RUN;
            end
        endcase
    end

    // Boot state and captured lock; only a reset can lower the lock.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= DPSL_ST_BOOT;
            locked_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            locked_r <= locked_nxt;
        end
    end

    // Port setup; writes before the lock is captured are dropped, so a
    // locked part never shows a port for even one cycle.
    always_comb begin
        logic jr, sr, tr, pr;
        jr = (fw_dbg == DPSL_DBG_JTAG);
        sr = (fw_dbg == DPSL_DBG_SWD);
        tr = (fw_trc == DPSL_TRC_SERIAL) && !jr;
        pr = (fw_trc == DPSL_TRC_PARALLEL);
        jt_nxt = jt_r;
        sw_nxt = sw_r;
        st_en_nxt = st_en_r;
        pt_nxt = pt_r;
        if (fw_dbg_wr && st_r == DPSL_ST_RUN) begin
            jt_nxt = jr;
            sw_nxt = sr;
            st_en_nxt = tr;
            pt_nxt = pr;
        end
        if (locked_r) begin
            jt_nxt = 1'b0;
            sw_nxt = 1'b0;
            st_en_nxt = 1'b0;
            pt_nxt = 1'b0;
        end
        pins_nxt = dpsl_pins(jt_nxt, sw_nxt, st_en_nxt, pt_nxt);
    end

    // Port enables and pin count; all ports come out of reset disabled.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            jt_r <= 1'b0;
            sw_r <= 1'b0;
            st_en_r <= 1'b0;
            pt_r <= 1'b0;
            pins_r <= 4'h0;
        end else begin
            jt_r <= jt_nxt;
            sw_r <= sw_nxt;
            st_en_r <= st_en_nxt;
            pt_r <= pt_nxt;
            pins_r <= pins_nxt;
        end
    end

    // Latch read-back; a read with the serial port off keeps the old word.
    always_comb begin
        rd_nxt = rd_r;
        if (swd_rd && sw_r) begin
            rd_nxt = vif.latch_q;
        end
    end

    // Read-back register.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_r <= 32'h00000000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // Protection level; an erase while unlocked wins over a raise in the same cycle.
    always_comb begin
        prot_nxt = prot_r;
        if (full_erase && !locked_r) begin
            prot_nxt = `DPSL_PROT_NONE;
        end else if (prot_wr && prot_data > prot_r) begin
            prot_nxt = prot_data;
        end
    end

    // Protection register.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prot_r <= `DPSL_PROT_NONE;
        end else begin
            prot_r <= prot_nxt;
        end
    end

    // Block grant and key refusal pulses, each one cycle long.
    always_comb begin
        grant_nxt = blk_req && !locked_r && !blk_secure[blk_idx];
        ref_nxt = key_wr && !vif.wr_en;
    end

    // Pulse registers.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            grant_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            ref_r <= ref_nxt;
        end
    end

    // Every output comes straight from its register.
    assign locked = locked_r;
    assign swd_rdata = rd_r;
    assign jtag_en = jt_r;
    assign swd_en = sw_r;
    assign strace_en = st_en_r;
    assign ptrace_en = pt_r;
    assign pins_used = pins_r;
    assign prot_level = prot_r;
    assign blk_grant = grant_r;
    assign key_refused = ref_r;
endmodule : dpsl_lock

// *** dpsl_lock_assertions.sv ***
// Checker for the debug port security lock.
`timescale 1ns/1ps
module dpsl_lock_assertions (
    input wire logic ref_clk, // Clock.
    input wire logic rstn, // Reset.
    input wire logic key_wr, // Key strobe.
    input wire logic full_erase, // Erase strobe.
    input wire logic blk_req, // Block request.
    input wire logic [3:0] blk_idx, // Block index.
    input wire logic [15:0] blk_secure, // Block security.
    input wire logic locked, // Lock.
    input wire logic jtag_en, // JTAG on.
    input wire logic swd_en, // SWD on.
    input wire logic strace_en, // Serial trace on.
    input wire logic ptrace_en, // Parallel trace on.
    input wire logic [3:0] pins_used, // Pin count.
    input wire logic [1:0] prot_level, // Protection.
    input wire logic blk_grant, // Grant.
    input wire logic key_refused // Refusal.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A lock keeps ports shut and cannot fall before reset, so no window opens.
    a_ports_off: assert property (locked |-> !(jtag_en | swd_en | strace_en | ptrace_en))
        else $error("port on while locked");
    a_lock_hold: assert property ($past(locked) |-> locked)
        else $error("lock dropped");
    a_key_refuse: assert property (key_wr && (locked || prot_level != 2'h0) |=> key_refused)
        else $error("key write not refused");
    a_refuse_cause: assert property (key_refused |-> $past(key_wr))
        else $error("refusal without key write");
    a_prot_keep: assert property (!full_erase |=> prot_level >= $past(prot_level))
        else $error("protection lowered");
    a_blk_gate: assert property (blk_grant |-> $past(blk_req) && !$past(blk_secure[blk_idx]))
        else $error("bad block grant");
    a_pin_count: assert property (pins_used ==
        4'h4 * jtag_en + 4'h2 * swd_en + 4'h1 * strace_en + 4'h5 * ptrace_en)
        else $error("pin count wrong");
    a_trace_pair: assert property (!(jtag_en && strace_en))
        else $error("serial trace with JTAG");
endmodule : dpsl_lock_assertions

// *** dpsl_host_model.sv ***
// Host probe model that writes the key and resets the part.
`timescale 1ns/1ps
module dpsl_host_model (
    input wire logic ref_clk, // Clock.
    output logic key_wr, // Key strobe.
    output logic [31:0] key_data, // Key value.
    output logic host_rstn // Reset request.
);
    initial {key_wr, key_data, host_rstn} = 34'h1;
    // Released data goes inverted, so a stale key never looks valid.
    task write_key(input logic [31:0] k);
        @(negedge ref_clk) {key_wr, key_data} = {1'h1, k};
        @(negedge ref_clk) {key_wr, key_data} = {1'h0, ~k};
    endtask : write_key
    // Reset after the commit, since the lock is only sampled then.
    task reset_part;
        @(negedge ref_clk) host_rstn = 1'h0;
        repeat (2) @(negedge ref_clk);
        host_rstn = 1'h1;
    endtask : reset_part
endmodule : dpsl_host_model

// *** tb_top.sv ***
// Self-checking bench for the debug port security lock.
`timescale 1ns/1ps
`include "dpsl_params.svh"
module tb_top;
    import dpsl_pkg::*;
    logic ref_clk = 1'h0, tb_rstn = 1'h0, swd_rd = 1'h0, fw_dbg_wr = 1'h0, prot_wr = 1'h0;
    logic full_erase = 1'h0, blk_req = 1'h0;
    logic [1:0] prot_data = 2'h0, o;
    logic [3:0] blk_idx = 4'h2;
    logic [15:0] blk_secure = 16'h0004;
    dpsl_dbg_t fw_dbg = DPSL_DBG_NONE;
    dpsl_trc_t fw_trc = DPSL_TRC_NONE;
    dpsl_op_t blk_op = DPSL_OP_ERASE;
    wire logic key_wr, host_rstn, locked, jtag_en, swd_en, strace_en, ptrace_en, blk_grant;
    wire logic key_refused;
    wire logic [31:0] key_data, swd_rdata;
    wire logic [3:0] pins_used;
    wire logic [1:0] prot_level;
    wire logic rstn = tb_rstn & host_rstn;
    int bad_count = 0, comparisons = 0;
    // Rows: debug, trace, then JTAG, SWD, serial, parallel enables and pin count.
    logic [11:0] rows [9] = '{12'h000, 12'h484, 12'h842, 12'h121, 12'h215,
        12'h699, 12'h584, 12'hA57, 12'h963};
    dpsl_lock u_dpsl_lock (
        .ref_clk(ref_clk), .rstn(rstn), .key_wr(key_wr), .key_data(key_data),
        .swd_rd(swd_rd), .fw_dbg_wr(fw_dbg_wr), .fw_dbg(fw_dbg), .fw_trc(fw_trc),
        .prot_wr(prot_wr), .prot_data(prot_data), .full_erase(full_erase),
        .blk_req(blk_req), .blk_op(blk_op), .blk_idx(blk_idx), .blk_secure(blk_secure),
        .locked(locked), .swd_rdata(swd_rdata), .jtag_en(jtag_en), .swd_en(swd_en),
        .strace_en(strace_en), .ptrace_en(ptrace_en), .pins_used(pins_used),
        .prot_level(prot_level), .blk_grant(blk_grant), .key_refused(key_refused)
    );
    dpsl_host_model u_dpsl_host_model (
        .ref_clk(ref_clk), .key_wr(key_wr), .key_data(key_data), .host_rstn(host_rstn)
    );
    always #20 ref_clk = ~ref_clk;
    task chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Strobes last one cycle; pulses are gathered over a short window.
    task go;
        o = {blk_grant, key_refused}; // Catches a pulse raised just before the call.
        repeat (4) begin
            @(negedge ref_clk);
            o = o | {blk_grant, key_refused};
            {swd_rd, fw_dbg_wr, prot_wr, full_erase, blk_req} = 5'h0;
        end
    endtask : go
    task test_done;
        $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Main sequence: table of port setups, then hand-written cases.
    initial begin
        repeat (16) @(negedge ref_clk);
        tb_rstn = 1'h1;
        go();
        chk({locked, jtag_en, swd_en, strace_en, ptrace_en, pins_used, prot_level}, 0);
        for (int i = 0; i < 9; i++) begin
            fw_dbg = dpsl_dbg_t'(rows[i][11:10]);
            fw_trc = dpsl_trc_t'(rows[i][9:8]);
            fw_dbg_wr = 1'h1;
            go();
            chk({jtag_en, swd_en, strace_en, ptrace_en, pins_used}, rows[i][7:0]);
        end
        $display("test table done");
        blk_req = 1'h1;
        go();
        chk(o[1], 0);
        {blk_idx, blk_req} = {4'h3, 1'h1};
        go();
        chk(o[1], 1);
        {prot_data, prot_wr} = {2'h2, 1'h1};
        go();
        {prot_data, prot_wr} = {2'h1, 1'h1};
        go();
        chk(prot_level, 2'h2);
        u_dpsl_host_model.write_key(`DPSL_KEY_PATTERN);
        go();
        chk(o[0], 1);
        full_erase = 1'h1;
        go();
        chk(prot_level, 0);
        $display("test flash done");
        u_dpsl_host_model.write_key(`DPSL_KEY_PATTERN ^ 32'h0000001F);
        u_dpsl_host_model.reset_part();
        go();
        chk(locked, 0);
        u_dpsl_host_model.write_key(`DPSL_KEY_PATTERN ^ 32'hF0000000);
        go();
        fw_dbg = DPSL_DBG_SWD;
        fw_trc = DPSL_TRC_NONE;
        fw_dbg_wr = 1'h1;
        go();
        swd_rd = 1'h1;
        go();
        chk({locked, swd_en, swd_rdata}, {2'h1, `DPSL_KEY_PATTERN ^ 32'hF0000000});
        u_dpsl_host_model.reset_part();
        go();
        chk(locked, 1);
        u_dpsl_host_model.write_key(`DPSL_KEY_PATTERN);
        go();
        chk(o[0], 1);
        fw_dbg = DPSL_DBG_JTAG;
        fw_dbg_wr = 1'h1;
        go();
        chk({locked, jtag_en, pins_used}, 6'h20);
        $display("test lock done");
        test_done();
    end
endmodule : tb_top
bind dpsl_lock dpsl_lock_assertions u_dpsl_lock_assertions (
    .ref_clk(ref_clk), .rstn(rstn), .key_wr(key_wr), .full_erase(full_erase),
    .blk_req(blk_req), .blk_idx(blk_idx), .blk_secure(blk_secure), .locked(locked),
    .jtag_en(jtag_en), .swd_en(swd_en), .strace_en(strace_en), .ptrace_en(ptrace_en),
    .pins_used(pins_used), .prot_level(prot_level), .blk_grant(blk_grant),
    .key_refused(key_refused)
);
